// File: src/dsc_serial_ctrl.sv
// Top of the dual converter serial control: strobes, sequencing, frames
//
// Functional notes
// - Control bits enter MSB first, one per edge.
// - Control word resets to all zeros.
// - Word holds channel, feature, sleep, read, action fields.
// - Channel code picks the input pair connection.
// - Feature code picks pair or extra features.
// - Sleep and reference-off bits enable their function.
// - Special read only acts in single-output modes.
// - Action codes arm DAC access or reset.
// - Settings take effect on the twelfth edge.
// - Select pin chooses manual or automatic channels.
// - Output pin chooses both outputs or first only.
// - Result bits valid from third edge after strobe.
// - Trigger starts a sixteen-cycle conversion.
// - Busy stays high for the whole conversion.
// - Manual mode latches next channel at cycle two.
// - Manual dual frame: two zeros, result, two zeros.
// - Manual single mode ignores alternate triggers.
// - Manual single frame: zero, converter flag, result, zeros.
// - Automatic dual frame: channel flag, zero, result, zeros.
// - Automatic single: second output floats, flags lead.
// - Special read returns both results per strobe.
// - DAC write takes two accesses, no channel latch.
`default_nettype none
module dsc_serial_ctrl (
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   // Host strobes and serial input, asynchronous
   input  wire logic                          sample_trigger,
   input  wire logic                          read_strobe,
   input  wire logic                          config_serial_in,
   input  wire logic                          out_select_n,
   // Mode pins, asynchronous
   input  wire logic                          select_mode_pin,
   input  wire logic                          output_mode_pin,
   // Converter results, same clock domain
   input  wire logic [dsc_pkg::RES_W-1:0]     result_a,
   input  wire logic [dsc_pkg::RES_W-1:0]     result_b,
   // Status and analog control
   output logic                               busy,
   output logic [1:0]                         mux_code,
   output logic                               power_down,
   output logic                               deep_sleep,
   output logic                               light_sleep,
   output logic                               ref_off,
   output logic [dsc_pkg::DAC_W-1:0]          dac_value,
   // Serial outputs
   output logic                               serial_out_first,
   output logic                               serial_out_first_oe,
   output logic                               serial_out_second,
   output logic                               serial_out_second_oe
);
   import dsc_pkg::*;

   dsc_cfg_if cfg ();

   dsc_ctl_word u_ctl (
      .core_clk (core_clk),
      .rst      (rst),
      .cfg      (cfg.ctl)
   );

   logic [5:0]       meta_reg, sync_reg;
   logic [1:0]       prev_reg;
   dsc_conv_t        state_reg,  state_next;
   logic [3:0]       ccnt_reg,   ccnt_next;
   logic             busy_reg,   busy_next;
   logic             pair_reg,   pair_next;
   logic             npair_reg,  npair_next;
   logic [RES_W-1:0] resa_reg,   resa_next;
   logic [RES_W-1:0] resb_reg,   resb_next;
   logic             rpair_reg,  rpair_next;
   logic             bpend_reg,  bpend_next;
   logic             bsel_reg,   bsel_next;
   logic             float_reg,  float_next;
   logic             pd_reg,     pd_next;
   logic [1:0]       mux_reg,    mux_next;
   logic [1:0]       pend_reg,   pend_next;
   logic [SH_W-1:0]  sha_reg,    sha_next;
   logic [SH_W-1:0]  shb_reg,    shb_next;
   logic             oea_reg,    oea_next;
   logic             oeb_reg,    oeb_next;
   logic             fstart_reg, fstart_next;
   logic             trig_rise, rd_rise, auto_m, single_m, special, stop, accept, load;
   logic [FRAME_W-1:0] fa, fb;

   // Build one result frame from mode flags and result
   function automatic logic [FRAME_W-1:0] mk_frame(input logic am, input logic sm,
      input logic pb, input logic cb, input logic [RES_W-1:0] r);
      mk_frame = {am & pb, sm & cb, r, 2'h0};
   endfunction

   // Two-flop synchronisers: trigger, strobe, bit, select, two mode pins
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= 6'h08;
         sync_reg <= 6'h08;
      end
      else
      begin
         meta_reg <= {output_mode_pin, select_mode_pin, out_select_n,
                      config_serial_in, read_strobe, sample_trigger};
         sync_reg <= meta_reg;
      end
   end

   // Pin decodes, all from synchronised copies
   assign trig_rise   = sync_reg[0] & ~prev_reg[0];
   assign rd_rise     = sync_reg[1] & ~prev_reg[1];
   assign auto_m      = sync_reg[4];
   assign single_m    = sync_reg[5];
   assign special     = cfg.word[BIT_SPECIAL] & single_m;
   assign stop        = cfg.word[BIT_DEEP] | cfg.word[BIT_LIGHT];
   assign cfg.rd_pulse = rd_rise;
   assign cfg.cfg_bit  = sync_reg[2];
   // A pending second result blocks a new start so it is not overwritten
   assign accept      = trig_rise & ~stop & ~(single_m & ~special & bpend_reg);
   assign fa          = mk_frame(auto_m, single_m, rpair_reg, 1'b0, resa_reg);
   assign fb          = mk_frame(auto_m, single_m, rpair_reg, 1'b1, resb_reg);

   // Conversion sequencer, channel choice and frame loading
   always_comb
   begin
      state_next  = state_reg;
      ccnt_next   = ccnt_reg;
      busy_next   = busy_reg;
      pair_next   = pair_reg;
      npair_next  = npair_reg;
      resa_next   = resa_reg;
      resb_next   = resb_reg;
      rpair_next  = rpair_reg;
      bpend_next  = bpend_reg;
      bsel_next   = bsel_reg;
      float_next  = float_reg & single_m;
      pend_next   = pend_reg;
      load        = 1'b0;
      sha_next    = {sha_reg[SH_W-2:0], 1'b0};
      shb_next    = {shb_reg[SH_W-2:0], 1'b0};
      case (state_reg)
         CS_IDLE, CS_SLEEP:
         begin
            // Starts while busy never reach here
            if (accept)
            begin
               state_next = CS_CONV;
               ccnt_next  = 4'h0;
               busy_next  = 1'b1;
               pair_next  = npair_reg;
            end
         end
         CS_CONV:
         begin
            ccnt_next = ccnt_reg + 4'h1;
            if (stop)
            begin
               // Deep or light sleep aborts a running conversion
               state_next = CS_IDLE;
               busy_next  = 1'b0;
            end
            else
            begin
               if (ccnt_reg == CH_LATCH_CYC && !auto_m && !cfg.acc_dac_wr)
                  npair_next = sync_reg[2];
               if (ccnt_reg == RESULT_CYC)
               begin
                  resa_next  = result_a;
                  resb_next  = result_b;
                  rpair_next = pair_reg;
               end
               if (ccnt_reg == CONV_LAST)
               begin
                  busy_next  = 1'b0;
                  state_next = cfg.word[BIT_AUTO] ? CS_SLEEP : CS_IDLE;
                  if (auto_m)
                     npair_next = ~pair_reg;
                  float_next = single_m;
                  bpend_next = single_m & ~special;
                  bsel_next  = 1'b0;
               end
            end
         end
         default:
         begin
            state_next = CS_IDLE;
            busy_next  = 1'b0;
         end
      endcase
      // Frame load on the third edge after the strobe
      if (rd_rise)
         pend_next = 2'h1;
      else if (pend_reg == DOUT_LOAD)
      begin
         pend_next = 2'h0;
         load      = 1'b1;
      end
      else if (pend_reg != 2'h0)
         pend_next = pend_reg + 2'h1;
      if (load)
      begin
         shb_next = {fb, {FRAME_W{1'b0}}};
         if (cfg.acc_dac_rd)
            sha_next = {4'h0, cfg.dac, 2'h0, {FRAME_W{1'b0}}};
         else if (special && auto_m)
            sha_next = {fa, fb};
         else if (single_m && !special && bsel_reg)
         begin
            sha_next   = {fb, {FRAME_W{1'b0}}};
            bpend_next = 1'b0;
         end
         else
         begin
            sha_next  = {fa, {FRAME_W{1'b0}}};
            bsel_next = single_m & ~special;
         end
      end
      // Soft reset idles the sequencer and clears the next channel, pending result, frame load and shift registers
      if (cfg.soft_rst)
      begin
         state_next = CS_IDLE;
         busy_next  = 1'b0;
         npair_next = 1'b0;
         bpend_next = 1'b0;
         bsel_next  = 1'b0;
         pend_next  = 2'h0;
         load       = 1'b0;
         sha_next   = {SH_W{1'b0}};
         shb_next   = {SH_W{1'b0}};
      end
   end

   // Output side decodes; pseudo-differential codes only in manual mode
   always_comb
   begin
      mux_next    = (cfg.word[FEAT_HI:FEAT_LO] == FEAT_EXTRA && !auto_m) ?
                    cfg.word[CH_HI:CH_LO] : {pair_next, pair_next};
      pd_next     = stop | (state_next == CS_SLEEP);
      fstart_next = load;
      oea_next    = ~sync_reg[3];
      // Second output floats in single mode unless manual special read
      oeb_next    = ~sync_reg[3] & ~(float_reg & ~(special & ~auto_m));
   end

   // State registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         prev_reg   <= 2'h0;
         state_reg  <= CS_IDLE;
         ccnt_reg   <= 4'h0;
         busy_reg   <= 1'b0;
         pair_reg   <= 1'b0;
         npair_reg  <= 1'b0;
         resa_reg   <= {RES_W{1'b0}};
         resb_reg   <= {RES_W{1'b0}};
         rpair_reg  <= 1'b0;
         bpend_reg  <= 1'b0;
         bsel_reg   <= 1'b0;
         float_reg  <= 1'b0;
         pd_reg     <= 1'b0;
         mux_reg    <= 2'h0;
         pend_reg   <= 2'h0;
         sha_reg    <= {SH_W{1'b0}};
         shb_reg    <= {SH_W{1'b0}};
         oea_reg    <= 1'b0;
         oeb_reg    <= 1'b0;
         fstart_reg <= 1'b0;
      end
      else
      begin
         prev_reg   <= sync_reg[1:0];
         state_reg  <= state_next;
         ccnt_reg   <= ccnt_next;
         busy_reg   <= busy_next;
         pair_reg   <= pair_next;
         npair_reg  <= npair_next;
         resa_reg   <= resa_next;
         resb_reg   <= resb_next;
         rpair_reg  <= rpair_next;
         bpend_reg  <= bpend_next;
         bsel_reg   <= bsel_next;
         float_reg  <= float_next;
         pd_reg     <= pd_next;
         mux_reg    <= mux_next;
         pend_reg   <= pend_next;
         sha_reg    <= sha_next;
         shb_reg    <= shb_next;
         oea_reg    <= oea_next;
         oeb_reg    <= oeb_next;
         fstart_reg <= fstart_next;
      end
   end

   // Outputs, all from flip-flops
   assign busy                 = busy_reg;
   assign mux_code             = mux_reg;
   assign power_down           = pd_reg;
   assign deep_sleep           = cfg.word[BIT_DEEP];
   assign light_sleep          = cfg.word[BIT_LIGHT];
   assign ref_off              = cfg.word[BIT_REFOFF];
   assign dac_value            = cfg.dac;
   assign serial_out_first     = sha_reg[SH_W-1];
   assign serial_out_first_oe  = oea_reg;
   assign serial_out_second    = shb_reg[SH_W-1];
   assign serial_out_second_oe = oeb_reg;

   AST_BUSY_LEN: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst || stop)
      $rose(busy_reg) |-> busy_reg[*8] ##1 busy_reg[*8] ##1 !busy_reg)
      else $error("busy did not span sixteen cycles");

   AST_BUSY_END: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst)
      $fell(busy_reg) && !$past(stop) && !$past(cfg.soft_rst)
      |-> $past(ccnt_reg) == CONV_LAST)
      else $error("busy fell before conversion end");

   AST_DATA_START: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst)
      rd_rise ##1 !rd_rise ##1 !rd_rise |=> fstart_reg)
      else $error("frame not started on third edge after strobe");

   AST_TAIL_ZERO: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst)
      fstart_reg ##1 (!fstart_reg)[*8] ##1 (!fstart_reg)[*5]
      |=> (!shb_reg[SH_W-1] || fstart_reg) ##1 (!shb_reg[SH_W-1] || fstart_reg))
      else $error("frame does not end in two zeros");

   AST_CH_LATCH: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst)
      state_reg == CS_CONV && ccnt_reg == CH_LATCH_CYC && !auto_m && !stop
      && !cfg.acc_dac_wr |=> npair_reg == $past(sync_reg[2]))
      else $error("manual channel not latched at second cycle");

   AST_AUTO_TOGGLE: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst)
      state_reg == CS_CONV && ccnt_reg == CONV_LAST && auto_m && !stop
      |=> npair_reg != pair_reg)
      else $error("automatic mode did not alternate channel");

   AST_B_FLOAT: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst)
      float_reg && !(special && !auto_m) |=> !serial_out_second_oe)
      else $error("second output driven in single-output mode");

   AST_ALT_IGNORE: assert property (@(posedge core_clk)
      disable iff (rst || cfg.soft_rst)
      state_reg == CS_IDLE && trig_rise && bpend_reg && single_m && !special
      |=> state_reg == CS_IDLE && !busy_reg)
      else $error("trigger honoured while second result pending");

   AST_CS_GATE: assert property (@(posedge core_clk)
      disable iff (rst)
      sync_reg[3] |=> !serial_out_first_oe && !serial_out_second_oe)
      else $error("outputs driven with output select high");
endmodule
`default_nettype wire

// File: src/dsc_pkg.sv
// Shared constants and types of the dual converter serial control block
`default_nettype none
package dsc_pkg;
   // Widths
   localparam int CW_W    = 12;
   localparam int RES_W   = 12;
   localparam int DAC_W   = 10;
   localparam int FRAME_W = 16;
   localparam int SH_W    = 32;
   // Control word field positions
   localparam int CH_HI       = 11;
   localparam int CH_LO       = 10;
   localparam int FEAT_HI     = 9;
   localparam int FEAT_LO     = 8;
   localparam int BIT_DEEP    = 7;
   localparam int BIT_LIGHT   = 6;
   localparam int BIT_AUTO    = 5;
   localparam int BIT_REFOFF  = 4;
   localparam int BIT_SPECIAL = 3;
   localparam int ACT_HI      = 2;
   localparam int ACT_LO      = 0;
   // Reset values
   localparam logic [CW_W-1:0]  CW_RESET  = 12'h000;
   localparam logic [DAC_W-1:0] DAC_RESET = 10'h3FF;
   // Field codes
   localparam logic [1:0] FEAT_EXTRA   = 2'h1;
   localparam logic [2:0] ACT_DAC_WR   = 3'h1;
   localparam logic [2:0] ACT_DAC_RD   = 3'h3;
   localparam logic [2:0] ACT_SOFT_RST = 3'h5;
   // Cycle counts
   localparam logic [3:0] CW_LAST      = 4'hB;
   localparam logic [3:0] CONV_LAST    = 4'hF;
   localparam logic [3:0] CH_LATCH_CYC = 4'h1;
   localparam logic [3:0] RESULT_CYC   = 4'hC;
   localparam logic [1:0] DOUT_LOAD    = 2'h2;
   // Conversion sequencer states
   typedef enum logic [2:0] {
      CS_IDLE  = 3'b001,
      CS_CONV  = 3'b010,
      CS_SLEEP = 3'b100
   } dsc_conv_t;
endpackage
`default_nettype wire

// File: src/dsc_cfg_if.sv
// Link between the serial control word capture and the conversion core
`default_nettype none
interface dsc_cfg_if;
   import dsc_pkg::*;
   logic             rd_pulse;
   logic             cfg_bit;
   logic [CW_W-1:0]  word;
   logic [DAC_W-1:0] dac;
   logic             acc_dac_wr;
   logic             acc_dac_rd;
   logic             soft_rst;
   modport ctl  (input rd_pulse, cfg_bit, output word, dac, acc_dac_wr, acc_dac_rd, soft_rst);
   modport core (output rd_pulse, cfg_bit, input word, dac, acc_dac_wr, acc_dac_rd, soft_rst);
endinterface
`default_nettype wire

// File: src/dsc_ctl_word.sv
// Serial control word capture, reference DAC register and soft reset
`default_nettype none
module dsc_ctl_word (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Link to the core
   dsc_cfg_if.ctl    cfg
);
   import dsc_pkg::*;

   logic [CW_W-1:0]  sh_reg,     sh_next;
   logic [3:0]       cnt_reg,    cnt_next;
   logic [CW_W-1:0]  word_reg,   word_next;
   logic [DAC_W-1:0] dac_reg,    dac_next;
   logic             arm_wr_reg, arm_wr_next;
   logic             arm_rd_reg, arm_rd_next;
   logic             acc_wr_reg, acc_wr_next;
   logic             acc_rd_reg, acc_rd_next;
   logic             srst_reg,   srst_next;
   logic             apply_reg,  apply_next;
   logic [CW_W-1:0]  nw;

   // Shift in MSB first, one bit per edge, settle on the twelfth
   always_comb
   begin
      nw          = {sh_reg[CW_W-2:0], cfg.cfg_bit};
      sh_next     = sh_reg;
      cnt_next    = cnt_reg;
      word_next   = word_reg;
      dac_next    = dac_reg;
      arm_wr_next = arm_wr_reg;
      arm_rd_next = arm_rd_reg;
      acc_wr_next = acc_wr_reg;
      acc_rd_next = acc_rd_reg;
      srst_next   = 1'b0;
      apply_next  = 1'b0;
      if (cfg.rd_pulse)
      begin
         // A fresh strobe restarts capture; an armed access is consumed here
         sh_next     = nw;
         cnt_next    = 4'h1;
         acc_wr_next = arm_wr_reg;
         acc_rd_next = arm_rd_reg;
         arm_wr_next = 1'b0;
         arm_rd_next = 1'b0;
      end
      else if (cnt_reg != 4'h0)
      begin
         sh_next  = nw;
         cnt_next = cnt_reg + 4'h1;
         if (cnt_reg == CW_LAST)
         begin
            cnt_next    = 4'h0;
            apply_next  = 1'b1;
            acc_wr_next = 1'b0;
            acc_rd_next = 1'b0;
            if (acc_wr_reg)
               dac_next = nw[DAC_W-1:0];
            else if (!acc_rd_reg)
            begin
               if (nw[ACT_HI:ACT_LO] == ACT_SOFT_RST)
                  srst_next = 1'b1;
               else
               begin
                  word_next   = nw;
                  arm_wr_next = (nw[FEAT_HI:FEAT_LO] == FEAT_EXTRA) &&
                                (nw[ACT_HI:ACT_LO] == ACT_DAC_WR);
                  arm_rd_next = (nw[FEAT_HI:FEAT_LO] == FEAT_EXTRA) &&
                                (nw[ACT_HI:ACT_LO] == ACT_DAC_RD);
               end
            end
         end
      end
      // Soft reset returns the whole interface to its reset values, DAC to 3FF
      if (srst_next)
      begin
         sh_next     = CW_RESET;
         cnt_next    = 4'h0;
         word_next   = CW_RESET;
         dac_next    = DAC_RESET;
         arm_wr_next = 1'b0;
         arm_rd_next = 1'b0;
      end
   end

   // State registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sh_reg     <= CW_RESET;
         cnt_reg    <= 4'h0;
         word_reg   <= CW_RESET;
         dac_reg    <= DAC_RESET;
         arm_wr_reg <= 1'b0;
         arm_rd_reg <= 1'b0;
         acc_wr_reg <= 1'b0;
         acc_rd_reg <= 1'b0;
         srst_reg   <= 1'b0;
         apply_reg  <= 1'b0;
      end
      else
      begin
         sh_reg     <= sh_next;
         cnt_reg    <= cnt_next;
         word_reg   <= word_next;
         dac_reg    <= dac_next;
         arm_wr_reg <= arm_wr_next;
         arm_rd_reg <= arm_rd_next;
         acc_wr_reg <= acc_wr_next;
         acc_rd_reg <= acc_rd_next;
         srst_reg   <= srst_next;
         apply_reg  <= apply_next;
      end
   end

   assign cfg.word       = word_reg;
   assign cfg.dac        = dac_reg;
   assign cfg.acc_dac_wr = acc_wr_reg;
   assign cfg.acc_dac_rd = acc_rd_reg;
   assign cfg.soft_rst   = srst_reg;

   AST_CW_APPLY: assert property (@(posedge core_clk) disable iff (rst)
      cfg.rd_pulse ##1 (!cfg.rd_pulse)[*8] ##1 (!cfg.rd_pulse)[*3] |=> apply_reg)
      else $error("control word not applied on twelfth edge");

   AST_SOFT_RST: assert property (@(posedge core_clk) disable iff (rst)
      srst_reg |-> (word_reg == CW_RESET) && (dac_reg == DAC_RESET) && !arm_wr_reg)
      else $error("soft reset left control state set");
endmodule
`default_nettype wire

// File: sim/dsc_host.sv
// Host model for the serial control block
`default_nettype none
module dsc_host (
   // Clock and host pins
   input  wire logic clk,
   output logic      rd,
   output logic      cv,
   output logic      config_serial_in,
   // Device outputs
   input  wire logic oa,
   input  wire logic ob
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] fa, fb;
   // Quiet pins from time zero
   initial {rd, cv, config_serial_in} = 3'h0;
   // Word MSB first; frames shift in meanwhile
   task automatic access(input logic [11:0] w, input logic r, input logic c);
      @(posedge clk);
      {rd, cv} <= {r, c};
      fork
         for (int i = 11; i >= 0; i--)
         begin
            config_serial_in <= w[i];
            @(posedge clk);
         end
         for (int k = 0; k < 21; k++)
         begin
            @(negedge clk);
            fa = {fa[14:0], oa};
            fb = {fb[14:0], ob};
         end
      join
      @(posedge clk);
      {rd, cv, config_serial_in} <= {2'h0, ~w[0]}; // No stale bit once released
   endtask
endmodule
`default_nettype wire

// File: sim/dsc_serial_ctrl_tb_top.sv
// Self-checking bench of the dual converter serial control
`default_nettype none
module dsc_serial_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dsc_pkg::*;
   logic             core_clk = 1'b0;
   logic             rst = 1'b1;
   logic             osn, smp, omp, rd, cv, config_serial_in, busy, deep, light, refo, pd;
   logic [1:0]       mux;
   logic             oa, oae, ob, obe;
   logic [RES_W-1:0] ra, rb;
   logic [DAC_W-1:0] dac;
   int               fails = 0, tests_run = 0, cyc = 0, blen = 0;
   always #10 core_clk = ~core_clk;
   // Busy cycles so far; cut-off against hangs
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (busy === 1'b1) blen <= blen + 1;
      if (cyc == 600) end_sim(1);
   end
   // Far side host; a released output reads inverted so it can never pass a check
   dsc_host host (.clk(core_clk), .rd(rd), .cv(cv), .config_serial_in(config_serial_in),
      .oa(oae ? oa : ~oa), .ob(obe ? ob : ~ob));
   dsc_serial_ctrl uut (.core_clk(core_clk), .rst(rst), .sample_trigger(cv),
      .read_strobe(rd), .config_serial_in(config_serial_in), .out_select_n(osn),
      .select_mode_pin(smp), .output_mode_pin(omp), .result_a(ra), .result_b(rb),
      .busy(busy), .mux_code(mux), .power_down(pd), .deep_sleep(deep),
      .light_sleep(light), .ref_off(refo), .dac_value(dac), .serial_out_first(oa),
      .serial_out_first_oe(oae), .serial_out_second(ob), .serial_out_second_oe(obe));
   // Expected frame: two flag bits, the result, two trailing zeros
   function automatic logic [15:0] frm(input logic f1, input logic f0, input logic [11:0] r);
      return {f1, f0, r, 2'h0};
   endfunction
   // Compare and count
   task automatic check(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Verdict
   task automatic end_sim(input int extra);
      fails += extra;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Reset, frames, DAC write, sleep bits, soft reset
   initial
   begin
      void'($urandom(32'hE037));
      {osn, smp, omp} = 3'h0;
      ra = 12'($urandom);
      rb = 12'($urandom);
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      check("reset", 32'h03FF, {deep, light, refo, dac});
      host.access(12'h000, 1'b1, 1'b1);
      check("busy", 32'h0010, blen);
      host.access(12'h000, 1'b1, 1'b0);
      check("dual", {2'h0, ra, 4'h0, rb, 2'h0}, {host.fa, host.fb});
      omp <= 1'b1;
      host.access(12'h000, 1'b0, 1'b1);
      for (int n = 0; n < 2; n++)
      begin
         host.access(12'h000, 1'b1, 1'b0);
         check("single", {1'b0, n[0], n[0] ? rb : ra, 2'h0}, host.fa);
      end
      check("busy_oe", 32'h0040, {blen[30:0], obe});
      omp <= 1'b0;
      host.access({4'h1, 5'h00, ACT_DAC_WR}, 1'b1, 1'b0);
      host.access({2'h0, ra[9:0]}, 1'b1, 1'b0);
      check("dac", 32'(ra[9:0]), 32'(dac));
      // DAC read: first output carries the DAC value, second the B result
      host.access({4'h1, 5'h00, ACT_DAC_RD}, 1'b1, 1'b0);
      host.access(12'h000, 1'b1, 1'b0);
      check("dac_rd", {4'h0, ra[9:0], 4'h0, rb, 2'h0}, {host.fa, host.fb});
      host.access({4'h0, rb[2:1], 1'b0, rb[0], 4'h0}, 1'b1, 1'b0);
      check("sleep", 32'(rb[2:0]), {deep, light, refo});
      check("pd", 32'(rb[2] | rb[1]), 32'(pd));
      host.access({9'h000, ACT_SOFT_RST}, 1'b1, 1'b0);
      repeat (2) @(posedge core_clk);
      check("soft_rst", 32'h03FF, {deep, light, refo, dac});
      // Manual special read: one strobe gives both results, second output driven
      omp <= 1'b1;
      host.access(12'h008, 1'b1, 1'b1);
      host.access(12'h008, 1'b1, 1'b0);
      check("special", {frm(1'b0, 1'b0, ra), frm(1'b0, 1'b1, rb)}, {host.fa, host.fb});
      // Automatic dual mode: the pair flag alternates with every conversion
      omp <= 1'b0;
      smp <= 1'b1;
      host.access(12'h000, 1'b0, 1'b1);
      for (int n = 0; n < 2; n++)
      begin
         host.access(12'h000, 1'b1, ~n[0]);
         check("auto", {frm(n[0], 1'b0, ra), frm(n[0], 1'b0, rb)},
            {host.fa, host.fb});
      end
      check("mux", 32'h3, 32'(mux));
      end_sim(0);
   end
endmodule
`default_nettype wire
